/* File: pmcu_defs.vh */
/*
 * Constants of the pin mode configuration unit: register offsets, field
 * positions, mode and command codes, pad decode codes and reset values.
 * Assumes inclusion by pmcu_top.v and by the bench; holds definitions only.
 */
`ifndef PMCU_DEFS_VH
`define PMCU_DEFS_VH

`define PMCU_NPINS 19
`define PMCU_ADDR_W 8

`define PMCU_OFF_IFACE 8'h00
`define PMCU_OFF_CMD 8'h04
`define PMCU_OFF_GPIO 8'h08
`define PMCU_OFF_STATUS 8'h0C
`define PMCU_OFF_MASK 8'h10
`define PMCU_OFF_PINLVL 8'h14
`define PMCU_OFF_STORE 8'h18
`define PMCU_OFF_VIEW 8'h1C

`define PMCU_MODE_UNUSED 3'h0
`define PMCU_MODE_IFACE 3'h1
`define PMCU_MODE_WAKE 3'h2
`define PMCU_MODE_LED 3'h3
`define PMCU_MODE_GPIO 3'h4

`define PMCU_OP_GPIO 2'h0
`define PMCU_OP_LED 2'h1
`define PMCU_OP_WAKE 2'h2
`define PMCU_OP_FREE 2'h3

`define PMCU_CMD_PIN_LSB 0
`define PMCU_CMD_OP_LSB 8
`define PMCU_CMD_CFG_LSB 16

`define PMCU_CFG_AL_BIT 7
`define PMCU_CFG_IAV_BIT 6

`define PMCU_CODE_OFF 4'h0
`define PMCU_CODE_IN_FLOAT 4'h1
`define PMCU_CODE_IN_PD 4'h2
`define PMCU_CODE_IN_PU 4'h3
`define PMCU_CODE_PP_MED 4'h4
`define PMCU_CODE_PP_HIGH 4'h8
`define PMCU_CODE_MAX 4'h9

`define PMCU_DRV_LOW 2'h0
`define PMCU_DRV_MED 2'h1
`define PMCU_DRV_HIGH 2'h2

`define PMCU_OWN_NONE 2'h0
`define PMCU_OWN_SPI 2'h1
`define PMCU_OWN_SER2 2'h2
`define PMCU_OWN_SER1 2'h3

`define PMCU_ST_CONFLICT 0
`define PMCU_ST_INVALID 1
`define PMCU_ST_WAKE 2
`define PMCU_ST_DONE 3
`define PMCU_ST_W 4

`define PMCU_IFACE_RST 3'h7
`define PMCU_MASK_RST 4'h0

`endif

/* File: pmcu_pad_env.sv */
/* Board around the pins: outputs loop back, bench drivers, pulls.
   Assumes the bench sets ext_en for pins it means to hold. */
`timescale 1ns/1ps
module pmcu_pad_env #(
    parameter NPINS = 19
) (
    // Clock
    input wire sys_clk,
    // Pad controls
    input wire [NPINS-1:0] pad_out,
    input wire [NPINS-1:0] pad_oe,
    input wire [NPINS-1:0] pad_pull_up,
    input wire [NPINS-1:0] pad_pull_dn,
    // Bench drivers
    input wire [NPINS-1:0] ext_en,
    input wire [NPINS-1:0] ext_val,
    // Levels seen by the block
    output logic [NPINS-1:0] pad_in
);
    logic [NPINS-1:0] float_r = '0;
    // An undriven, unpulled pin wanders instead of settling kindly
    always @(posedge sys_clk) float_r <= ~float_r;
    always_comb begin
        for (int i = 0; i < NPINS; i++)
            pad_in[i] = pad_oe[i] ? pad_out[i] : ext_en[i] ? ext_val[i] :
                pad_pull_up[i] ? 1'b1 : pad_pull_dn[i] ? 1'b0 : float_r[i];
    end
endmodule // pmcu_pad_env

/* File: pmcu_top.v */
/*
 * Pin mode configuration unit: per-pin mode, 8-bit configuration word
 * decode, serial-interface ownership with conflict checks, wakeup
 * detection, stored-configuration restore and an APB register slave.
 * Assumes pad inputs synchronous to sys_clk and a pad cell that drives
 * the pin from pad_out when pad_oe is high.
 */
`timescale 1ns/1ps
`include "pmcu_defs.vh"

module pmcu_top #(
    parameter NPINS = `PMCU_NPINS
) (
    // Clock and reset
    input wire sys_clk,
    input wire rst_n,
    input wire por_n,
    input wire standby_exit,
    // APB slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [`PMCU_ADDR_W-1:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    // Interface and LED sources
    input wire spi_data_out,
    input wire spi_pending,
    input wire serial_one_transmit,
    input wire serial_two_transmit,
    input wire [NPINS-1:0] led_ctrl,
    // Pads
    input wire [NPINS-1:0] pad_in,
    output reg [NPINS-1:0] pad_out,
    output reg [NPINS-1:0] pad_oe,
    output reg [NPINS-1:0] pad_ie,
    output reg [NPINS-1:0] pad_pull_up,
    output reg [NPINS-1:0] pad_pull_dn,
    output reg [2*NPINS-1:0] pad_drive,
    // Events
    output reg wakeup_req,
    output reg irq
);

    // Fixed ownership map of the serial interface pins
    function [1:0] owner;
        input integer i;
        owner = (i <= 3 || i == 6) ? `PMCU_OWN_SPI
            : (i == 4 || i == 5) ? `PMCU_OWN_SER2
            : (i == 11 || i == 12) ? `PMCU_OWN_SER1 : `PMCU_OWN_NONE;
    endfunction

    function [3:0] iface_code;
        input integer i;
        iface_code = (i == 1) ? `PMCU_CODE_PP_HIGH
            : (i == 5 || i == 6 || i == 12) ? `PMCU_CODE_PP_MED
            : `PMCU_CODE_IN_FLOAT;
    endfunction

    function is_input;
        input [3:0] c;
        is_input = (c >= `PMCU_CODE_IN_FLOAT) && (c <= `PMCU_CODE_IN_PU);
    endfunction

    reg [2:0] mode_r [0:NPINS-1];
    reg [7:0] cfg_r [0:NPINS-1];
    reg [NPINS-1:0] wake_en_r, gpio_val_r;
    reg [2:0] iface_en_r;
    reg [2:0] st_mode_r [0:NPINS-1];
    reg [7:0] st_cfg_r [0:NPINS-1];
    reg [NPINS-1:0] st_wake_r, st_val_r;
    reg [2:0] st_iface_r;
    reg st_ok_r;
    reg [`PMCU_ST_W-1:0] status_r, mask_r;
    reg [4:0] view_sel_r;
    reg [NPINS-1:0] level_r;
    reg wake_hit_r;

    wire acc = psel & penable & pready;
    wire wr = acc & pwrite;
    wire rd = acc & ~pwrite;
    wire wr_iface = wr && paddr == `PMCU_OFF_IFACE;
    wire wr_cmd = wr && paddr == `PMCU_OFF_CMD;
    wire wr_gpio = wr && paddr == `PMCU_OFF_GPIO;
    wire wr_mask = wr && paddr == `PMCU_OFF_MASK;
    wire wr_store = wr && paddr == `PMCU_OFF_STORE;
    wire rd_status = rd && paddr == `PMCU_OFF_STATUS;
    wire restore = !rst_n || standby_exit;

    wire [4:0] c_pin = pwdata[`PMCU_CMD_PIN_LSB +: 5];
    wire [1:0] c_op = pwdata[`PMCU_CMD_OP_LSB +: 2];
    wire [7:0] c_cfg = pwdata[`PMCU_CMD_CFG_LSB +: 8];
    wire [3:0] c_code = c_cfg[3:0];

    // Command checks against the current owner and mode of the pin
    reg c_invalid, c_conflict, p_owned;
    reg [2:0] p_mode;
    reg [3:0] p_code;
    reg [1:0] p_own;
    integer k, m;
    always @* begin
        p_mode = `PMCU_MODE_UNUSED;
        p_code = `PMCU_CODE_OFF;
        p_own = `PMCU_OWN_NONE;
        for (k = 0; k < NPINS; k = k + 1) begin
            if (c_pin == k) begin
                p_mode = mode_r[k];
                p_own = owner(k);
                p_code = (mode_r[k] == `PMCU_MODE_IFACE) ? iface_code(k)
                    : cfg_r[k][3:0];
            end
        end
        p_owned = (p_own != `PMCU_OWN_NONE) && iface_en_r[p_own - 2'h1];
        c_invalid = (c_pin >= NPINS) || (c_code > `PMCU_CODE_MAX);
        if (c_op == `PMCU_OP_LED && !c_invalid && c_code != `PMCU_CODE_OFF)
            c_invalid = is_input(c_code);
        c_conflict = 1'b0;
        if (!c_invalid) begin
            if (c_op == `PMCU_OP_WAKE)
                c_conflict = !(p_mode == `PMCU_MODE_UNUSED
                    || is_input(p_code));
            else
                c_conflict = p_owned;
        end
    end

    // Interface enables refused while a pin of theirs serves GPIO or LED
    reg [2:0] i_block;
    always @* begin
        i_block = 3'h0;
        for (m = 0; m < NPINS; m = m + 1) begin
            if (owner(m) != `PMCU_OWN_NONE
                    && (mode_r[m] == `PMCU_MODE_GPIO
                    || mode_r[m] == `PMCU_MODE_LED))
                i_block[owner(m) - 2'h1] = 1'b1;
        end
    end
    wire [2:0] i_rise = pwdata[2:0] & ~iface_en_r;
    wire i_conflict = |(i_rise & i_block);

    integer n, p, r;
    always @(posedge sys_clk) begin
        if (restore) begin
            // Startup falls back to interface pins only when nothing stored
            for (n = 0; n < NPINS; n = n + 1) begin
                if (st_ok_r) begin
                    mode_r[n] <= st_mode_r[n];
                    cfg_r[n] <= st_cfg_r[n];
                end else begin
                    mode_r[n] <= (owner(n) != `PMCU_OWN_NONE)
                        ? `PMCU_MODE_IFACE : `PMCU_MODE_UNUSED;
                    cfg_r[n] <= 8'h00;
                end
            end
            wake_en_r <= st_ok_r ? st_wake_r : {NPINS{1'b0}};
            gpio_val_r <= st_ok_r ? st_val_r : {NPINS{1'b0}};
            iface_en_r <= st_ok_r ? st_iface_r : `PMCU_IFACE_RST;
        end else if (wr_cmd && !c_invalid && !c_conflict) begin
            for (n = 0; n < NPINS; n = n + 1) begin
                if (c_pin == n) begin
                    case (c_op)
                        `PMCU_OP_GPIO: begin
                            mode_r[n] <= (c_code == `PMCU_CODE_OFF)
                                ? `PMCU_MODE_UNUSED : `PMCU_MODE_GPIO;
                            cfg_r[n] <= c_cfg;
                            gpio_val_r[n] <= c_cfg[`PMCU_CFG_IAV_BIT];
                            wake_en_r[n] <= 1'b0;
                        end
                        `PMCU_OP_LED: begin
                            mode_r[n] <= (c_code == `PMCU_CODE_OFF)
                                ? `PMCU_MODE_UNUSED : `PMCU_MODE_LED;
                            cfg_r[n] <= c_cfg;
                            wake_en_r[n] <= 1'b0;
                        end
                        `PMCU_OP_WAKE: begin
                            wake_en_r[n] <= 1'b1;
                            if (mode_r[n] == `PMCU_MODE_UNUSED) begin
                                mode_r[n] <= `PMCU_MODE_WAKE;
                                cfg_r[n] <= {c_cfg[7:4], `PMCU_CODE_IN_FLOAT};
                            end else begin
                                cfg_r[n][`PMCU_CFG_AL_BIT] <=
                                    c_cfg[`PMCU_CFG_AL_BIT];
                            end
                        end
                        default: begin
                            mode_r[n] <= `PMCU_MODE_UNUSED;
                            wake_en_r[n] <= 1'b0;
                        end
                    endcase
                end
            end
        end else if (wr_iface && !i_conflict) begin
            iface_en_r <= pwdata[2:0];
            for (n = 0; n < NPINS; n = n + 1) begin
                if (owner(n) != `PMCU_OWN_NONE) begin
                    if (!pwdata[owner(n) - 2'h1]
                            && mode_r[n] == `PMCU_MODE_IFACE) begin
                        mode_r[n] <= `PMCU_MODE_UNUSED;
                        wake_en_r[n] <= 1'b0;
                    end else if (pwdata[owner(n) - 2'h1]) begin
                        mode_r[n] <= `PMCU_MODE_IFACE;
                    end
                end
            end
        end else if (wr_gpio) begin
            gpio_val_r <= pwdata[NPINS-1:0];
        end
    end

    // Persistent copy survives system reset; power-on or a store write with bit 1 set blanks it
    always @(posedge sys_clk) begin
        if (!por_n || (wr_store && pwdata[1])) begin
            st_ok_r <= 1'b0;
        end else if (wr_store && pwdata[0]) begin
            st_ok_r <= 1'b1;
        end
        if (wr_store && pwdata[0]) begin
            for (p = 0; p < NPINS; p = p + 1) begin
                st_mode_r[p] <= mode_r[p];
                st_cfg_r[p] <= cfg_r[p];
            end
            st_wake_r <= wake_en_r;
            st_val_r <= gpio_val_r;
            st_iface_r <= iface_en_r;
        end
    end

    // Per-pin pad decode
    wire [NPINS-1:0] wake_act;
    genvar g;
    generate
        for (g = 0; g < NPINS; g = g + 1) begin : pin
            wire [2:0] md = mode_r[g];
            wire hw = (md == `PMCU_MODE_IFACE);
            wire [3:0] code = hw ? iface_code(g) : cfg_r[g][3:0];
            wire al = hw | cfg_r[g][`PMCU_CFG_AL_BIT];
            wire off = (md == `PMCU_MODE_UNUSED)
                || (code == `PMCU_CODE_OFF);
            wire in_m = !off && is_input(code);
            wire out_m = !off && (code >= `PMCU_CODE_PP_MED);
            wire od = code[0];
            wire hw_val = (g == 1) ? spi_data_out : (g == 6) ? spi_pending
                : (g == 12) ? serial_one_transmit
                : serial_two_transmit;
            wire act = hw ? hw_val
                : (md == `PMCU_MODE_LED) ? led_ctrl[g]
                : gpio_val_r[g];
            wire phys = al ? act : ~act;
            wire [1:0] drv = (code >= `PMCU_CODE_PP_HIGH) ? `PMCU_DRV_HIGH
                : (code >= 4'h6) ? `PMCU_DRV_LOW : `PMCU_DRV_MED;
            assign wake_act[g] = wake_en_r[g] && in_m
                && (level_r[g] == al);
            always @(posedge sys_clk) begin
                if (!rst_n) begin
                    pad_out[g] <= 1'b0;
                    pad_oe[g] <= 1'b0;
                    pad_ie[g] <= 1'b0;
                    pad_pull_up[g] <= 1'b0;
                    pad_pull_dn[g] <= 1'b0;
                    pad_drive[2*g +: 2] <= `PMCU_DRV_LOW;
                end else begin
                    pad_out[g] <= out_m && !od && phys;
                    pad_oe[g] <= out_m && (!od || !phys);
                    pad_ie[g] <= in_m;
                    pad_pull_up[g] <= in_m && code == `PMCU_CODE_IN_PU;
                    pad_pull_dn[g] <= in_m && code == `PMCU_CODE_IN_PD;
                    pad_drive[2*g +: 2] <= out_m ? drv : `PMCU_DRV_LOW;
                end
            end
        end
    endgenerate

    // Status events; a set in the clearing cycle wins
    wire [`PMCU_ST_W-1:0] ev;
    wire wake_now = |wake_act;
    // Only bits the read returned are cleared, so a late event survives
    wire [`PMCU_ST_W-1:0] st_clr = rd_status ? prdata[`PMCU_ST_W-1:0]
        : {`PMCU_ST_W{1'b0}};
    assign ev[`PMCU_ST_CONFLICT] = (wr_cmd && !c_invalid && c_conflict)
        || (wr_iface && i_conflict);
    assign ev[`PMCU_ST_INVALID] = wr_cmd && c_invalid;
    assign ev[`PMCU_ST_WAKE] = wake_now && !wake_hit_r;
    assign ev[`PMCU_ST_DONE] = (wr_cmd && !c_invalid && !c_conflict)
        || (wr_iface && !i_conflict);

    // APB access answers in the second access cycle
    reg [31:0] rdat;
    always @* begin
        rdat = 32'h0000_0000;
        if (paddr == `PMCU_OFF_IFACE)
            rdat[2:0] = iface_en_r;
        else if (paddr == `PMCU_OFF_GPIO)
            rdat[NPINS-1:0] = gpio_val_r;
        else if (paddr == `PMCU_OFF_STATUS)
            rdat[`PMCU_ST_W-1:0] = status_r;
        else if (paddr == `PMCU_OFF_MASK)
            rdat[`PMCU_ST_W-1:0] = mask_r;
        else if (paddr == `PMCU_OFF_PINLVL)
            rdat[NPINS-1:0] = level_r;
        else if (paddr == `PMCU_OFF_STORE)
            rdat[0] = st_ok_r;
        else if (paddr == `PMCU_OFF_VIEW) begin
            for (r = 0; r < NPINS; r = r + 1) begin
                if (view_sel_r == r) begin
                    rdat[7:0] = cfg_r[r];
                    rdat[10:8] = mode_r[r];
                    rdat[12] = wake_en_r[r];
                end
            end
        end
    end
    wire mapped = paddr == `PMCU_OFF_IFACE || paddr == `PMCU_OFF_CMD
        || paddr == `PMCU_OFF_GPIO || paddr == `PMCU_OFF_STATUS
        || paddr == `PMCU_OFF_MASK || paddr == `PMCU_OFF_PINLVL
        || paddr == `PMCU_OFF_STORE || paddr == `PMCU_OFF_VIEW;

    always @(posedge sys_clk) begin
        if (!rst_n) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
            status_r <= {`PMCU_ST_W{1'b0}};
            mask_r <= `PMCU_MASK_RST;
            view_sel_r <= 5'h00;
            level_r <= {NPINS{1'b0}};
            wake_hit_r <= 1'b0;
            wakeup_req <= 1'b0;
            irq <= 1'b0;
        end else begin
            pready <= psel && penable && !pready;
            pslverr <= psel && penable && !pready && !mapped;
            prdata <= (psel && penable && !pready && !pwrite) ? rdat
                : 32'h0000_0000;
            status_r <= (status_r & ~st_clr) | ev;
            if (wr_mask)
                mask_r <= pwdata[`PMCU_ST_W-1:0];
            if (wr_cmd)
                view_sel_r <= c_pin;
            level_r <= pad_in;
            wake_hit_r <= wake_now;
            wakeup_req <= wake_now;
            irq <= |(((status_r & ~st_clr) | ev) & mask_r);
        end
    end

endmodule // pmcu_top

/* File: pmcu_top_monitor.sv */
/* Checker for pmcu_top: APB answer timing, pad decode sanity, reset.
   Assumes binding to pmcu_top, sharing its NPINS. */
`timescale 1ns/1ps
module pmcu_top_monitor #(
    parameter NPINS = 19
) (
    // Clock and reset
    input wire sys_clk,
    input wire rst_n,
    // APB
    input wire psel,
    input wire penable,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    // Pads and events
    input wire [NPINS-1:0] pad_oe,
    input wire [NPINS-1:0] pad_ie,
    input wire [NPINS-1:0] pad_pull_up,
    input wire [NPINS-1:0] pad_pull_dn,
    input wire [2*NPINS-1:0] pad_drive,
    input wire irq
);
    logic drv_bad;
    // Code 3 is no strength at all; a decode slip would land there
    always_comb begin
        drv_bad = 1'b0;
        for (int i = 0; i < NPINS; i++)
            drv_bad = drv_bad | (pad_drive[2*i +: 2] == 2'h3);
    end
    a_reset_pads_off: assert property (
        @(posedge sys_clk) !rst_n |=> pad_oe == '0 && pad_ie == '0 && !irq)
        else $error("pads or irq active after reset edge");
    a_pull_exclusive: assert property (
        @(posedge sys_clk) disable iff (!rst_n) (pad_pull_up & pad_pull_dn) == '0)
        else $error("pull-up and pull-down both on");
    a_pull_on_input: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        ((pad_pull_up | pad_pull_dn) & ~pad_ie) == '0)
        else $error("pull enabled on a pin without input");
    a_drive_legal: assert property (
        @(posedge sys_clk) disable iff (!rst_n) !drv_bad)
        else $error("illegal drive strength code");
    a_ready_timing: assert property (
        @(posedge sys_clk) disable iff (!rst_n) $rose(penable) && psel |=> pready)
        else $error("no answer in second access cycle");
    a_ready_single: assert property (
        @(posedge sys_clk) disable iff (!rst_n) pready |=> !pready)
        else $error("ready held longer than one cycle");
    a_ready_in_access: assert property (
        @(posedge sys_clk) disable iff (!rst_n) pready |-> psel && penable)
        else $error("ready outside an access phase");
    a_slverr_ready: assert property (
        @(posedge sys_clk) disable iff (!rst_n) pslverr |-> pready)
        else $error("error response without ready");
    a_rdata_idle: assert property (
        @(posedge sys_clk) disable iff (!rst_n) !pready |-> prdata == 32'h0)
        else $error("read data not zero while idle");
endmodule // pmcu_top_monitor

bind pmcu_top pmcu_top_monitor #(.NPINS(NPINS)) u_mon (
    .sys_clk(sys_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .pad_oe(pad_oe),
    .pad_ie(pad_ie), .pad_pull_up(pad_pull_up), .pad_pull_dn(pad_pull_dn),
    .pad_drive(pad_drive), .irq(irq));

/* File: tb_top.sv */
/* Self-checking bench for pmcu_top: reset defaults, command table, then wakeup,
   interface, store and restore cases. Assumes pmcu_defs.vh offsets. */
`timescale 1ns/1ps
`include "pmcu_defs.vh"
module tb_top;
    typedef struct packed {
        logic [4:0] pin;
        logic [1:0] op;
        logic [7:0] cfg;
        logic [3:0] st;
        logic chkv;
        logic [12:0] view;
        logic [6:0] pad;
    } pmcu_row_t;
    logic sys_clk = 1'b0, rst_n = 1'b0, por_n = 1'b0, standby_exit = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, rerr;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rdata;
    logic spi_data_out = 1'b1, spi_pending = 1'b0;
    logic serial_one_transmit = 1'b1, serial_two_transmit = 1'b1;
    logic [18:0] led_ctrl = '0, ext_val = '0, ext_en = '1, pad_in, pad_out;
    logic [18:0] pad_oe, pad_ie, pad_pull_up, pad_pull_dn;
    logic [37:0] pad_drive;
    logic wakeup_req, irq;
    int mismatches = 0, samples_checked = 0, cycles = 0;
    // pin, op, cfg, status, view checked, view, pad {oe,ie,pu,pd,drv,out}
    pmcu_row_t rows [19] = '{
        '{5'h07, 2'h0, 8'h81, 4'h8, 1'b1, 13'h0481, 7'h20},
        '{5'h08, 2'h0, 8'h02, 4'h8, 1'b1, 13'h0402, 7'h28},
        '{5'h09, 2'h0, 8'h03, 4'h8, 1'b1, 13'h0403, 7'h30},
        '{5'h0A, 2'h0, 8'hC4, 4'h8, 1'b1, 13'h04C4, 7'h43},
        '{5'h0D, 2'h0, 8'h45, 4'h8, 1'b1, 13'h0445, 7'h42},
        '{5'h0E, 2'h0, 8'h06, 4'h8, 1'b1, 13'h0406, 7'h41},
        '{5'h0F, 2'h0, 8'h87, 4'h8, 1'b1, 13'h0487, 7'h40},
        '{5'h10, 2'h1, 8'h48, 4'h8, 1'b1, 13'h0348, 7'h45},
        '{5'h11, 2'h1, 8'h89, 4'h8, 1'b1, 13'h0389, 7'h44},
        '{5'h12, 2'h0, 8'h00, 4'h8, 1'b1, 13'h0000, 7'h00},
        '{5'h03, 2'h0, 8'h01, 4'h1, 1'b0, 13'h0000, 7'h20},
        '{5'h07, 2'h0, 8'h0A, 4'h2, 1'b0, 13'h0000, 7'h20},
        '{5'h08, 2'h0, 8'h0F, 4'h2, 1'b0, 13'h0000, 7'h28},
        '{5'h10, 2'h1, 8'h01, 4'h2, 1'b0, 13'h0000, 7'h45},
        '{5'h07, 2'h2, 8'h80, 4'h8, 1'b0, 13'h0000, 7'h20},
        '{5'h12, 2'h2, 8'h80, 4'h8, 1'b0, 13'h0000, 7'h20},
        '{5'h0A, 2'h2, 8'h00, 4'h1, 1'b0, 13'h0000, 7'h43},
        '{5'h00, 2'h2, 8'h80, 4'h8, 1'b0, 13'h0000, 7'h20},
        '{5'h02, 2'h3, 8'h00, 4'h1, 1'b0, 13'h0000, 7'h20}};

    pmcu_top #(.NPINS(19)) DUT (.sys_clk, .rst_n, .por_n, .standby_exit,
        .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .spi_data_out, .spi_pending, .serial_one_transmit,
        .serial_two_transmit, .led_ctrl, .pad_in, .pad_out, .pad_oe, .pad_ie,
        .pad_pull_up, .pad_pull_dn, .pad_drive, .wakeup_req, .irq);
    pmcu_pad_env #(.NPINS(19)) u_env (.sys_clk, .pad_out, .pad_oe,
        .pad_pull_up, .pad_pull_dn, .ext_en, .ext_val, .pad_in);

    always #5 sys_clk = ~sys_clk;

    task report_and_stop();
        $display("Checks %0d, mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // Ceiling well above the few hundred cycles the run needs
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            report_and_stop();
        end
    end

    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        do @(posedge sys_clk); while (pready !== 1'b1);
        rdata = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task rd_chk(input string nm, input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(nm, rdata, exp);
    endtask

    // Status read also gives the pads their two edges to settle
    task cmd(input logic [4:0] pin, input logic [1:0] op,
             input logic [7:0] cfg, input logic [3:0] st);
        apb(1'b1, `PMCU_OFF_CMD, {8'h00, cfg, 6'h00, op, 3'h0, pin});
        rd_chk("status", `PMCU_OFF_STATUS, {28'h0, st});
    endtask

    task chk_pad(input int i, input logic [6:0] exp);
        chk($sformatf("pad %0d", i), {25'h0, pad_oe[i], pad_ie[i],
            pad_pull_up[i], pad_pull_dn[i], pad_drive[2*i +: 2],
            pad_out[i] & pad_oe[i]}, {25'h0, exp});
    endtask

    task do_reset(input logic por, input int n);
        rst_n <= 1'b0;
        por_n <= ~por;
        repeat (n) @(posedge sys_clk);
        rst_n <= 1'b1;
        por_n <= 1'b1;
        repeat (3) @(posedge sys_clk);
    endtask

    function automatic logic [6:0] def_pad(input int i);
        case (i)
            0, 2, 3, 4, 11: return 7'h20;
            1: return 7'h45;
            5, 12: return 7'h43;
            6: return 7'h42;
            default: return 7'h00;
        endcase
    endfunction

    initial begin
        do_reset(1'b1, 6);
        rd_chk("iface", `PMCU_OFF_IFACE, 32'h7);
        rd_chk("mask", `PMCU_OFF_MASK, 32'h0);
        rd_chk("unmapped", 8'h20, 32'h0);
        chk("slverr", {31'h0, rerr}, 32'h1);
        for (int i = 0; i < 19; i++) chk_pad(i, def_pad(i));
        apb(1'b0, `PMCU_OFF_STATUS, 32'h0);
        foreach (rows[k]) begin
            cmd(rows[k].pin, rows[k].op, rows[k].cfg, rows[k].st);
            if (rows[k].chkv)
                rd_chk("view", `PMCU_OFF_VIEW, {19'h0, rows[k].view});
            chk_pad(rows[k].pin, rows[k].pad);
        end
        chk("irq", {31'h0, irq}, 32'h0);
        apb(1'b1, `PMCU_OFF_GPIO, 32'h4000);
        led_ctrl <= 19'h10000;
        repeat (3) @(posedge sys_clk);
        chk_pad(14, 7'h40);
        chk_pad(10, 7'h42);
        chk_pad(13, 7'h02);
        chk_pad(16, 7'h44);
        spi_data_out <= 1'b0;
        spi_pending <= 1'b1;
        serial_two_transmit <= 1'b0;
        repeat (3) @(posedge sys_clk);
        chk_pad(1, 7'h44);
        chk_pad(6, 7'h43);
        chk_pad(5, 7'h42);
        apb(1'b1, `PMCU_OFF_MASK, 32'h4);
        apb(1'b0, `PMCU_OFF_STATUS, 32'h0);
        ext_val <= 19'h40000;
        repeat (5) @(posedge sys_clk);
        chk("wake", {31'h0, wakeup_req}, 32'h1);
        chk("irq", {31'h0, irq}, 32'h1);
        rd_chk("status", `PMCU_OFF_STATUS, 32'h4);
        ext_val <= 19'h0;
        repeat (2) @(posedge sys_clk);
        chk("irq", {31'h0, irq}, 32'h0);
        apb(1'b1, `PMCU_OFF_IFACE, 32'h3);
        rd_chk("status", `PMCU_OFF_STATUS, 32'h8);
        chk_pad(11, 7'h00);
        chk_pad(12, 7'h00);
        cmd(5'h0C, `PMCU_OP_GPIO, 8'h04, 4'h8);
        apb(1'b1, `PMCU_OFF_IFACE, 32'h7);
        rd_chk("status", `PMCU_OFF_STATUS, 32'h1);
        rd_chk("iface", `PMCU_OFF_IFACE, 32'h3);
        apb(1'b1, `PMCU_OFF_STORE, 32'h1);
        rd_chk("stored", `PMCU_OFF_STORE, 32'h1);
        cmd(5'h09, `PMCU_OP_FREE, 8'h00, 4'h8);
        chk_pad(9, 7'h00);
        standby_exit <= 1'b1;
        @(posedge sys_clk);
        standby_exit <= 1'b0;
        repeat (3) @(posedge sys_clk);
        chk_pad(9, 7'h30);
        cmd(5'h09, `PMCU_OP_FREE, 8'h00, 4'h8);
        do_reset(1'b0, 2);
        chk_pad(9, 7'h30);
        do_reset(1'b1, 2);
        chk_pad(9, 7'h00);
        rd_chk("stored", `PMCU_OFF_STORE, 32'h0);
        report_and_stop();
    end
endmodule // tb_top
